// >>> pkg/sbm_pkg.sv
// Constants and carrier types of the burst memory module port
package sbm_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 64;
  localparam int LANE_W = 8;
  localparam int LANES = 8;
  localparam int CHIPS = 2;
  localparam int CHIP_LANES = 4;
  localparam int CHIP_W = 32;
  localparam int BURST_W = 2;

  // Values after reset, and the burst step
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] BASE_RST = 15'h0000;
  localparam logic [LANE_W-1:0] LANE_RST = 8'h00;
  localparam logic SYNC_RST = 1'b1;
  localparam logic SEL_RST = 1'b0;

  // Order select when the pin floats: pulled high, interleaved
  localparam logic MODE_PULLUP = 1'b1;
  localparam logic MODE_LINEAR = 1'b0;

  // Grounded presence lines, bit i for line i
  localparam logic [3:0] PRES_GND_256K = 4'h4;
  localparam logic [3:0] PRES_GND_512K = 4'h5;
  localparam logic [3:0] PRES_GND = PRES_GND_256K;
  localparam logic [3:0] PRES_LEVEL = 4'h0;

  typedef enum logic [2:0] {
    SBM_IDLE = 3'b001,
    SBM_READ = 3'b010,
    SBM_WRITE = 3'b100
  } sbm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ctrl_addr_strobe_n;
    logic proc_addr_strobe_n;
    logic burst_advance_n;
    logic chip_en_n;
    logic depth_sel_hi;
    logic depth_sel_lo_n;
    logic byte_write_permit_n;
    logic all_bytes_write_n;
    logic [LANES-1:0] byte_lane_we_n;
    logic [DATA_W-1:0] data_io_bus;
  } sbm_pins_t;

  typedef struct packed {
    logic presence_id_bit3;
    logic presence_id_bit2;
    logic presence_id_bit1;
    logic presence_id_bit0;
  } sbm_presence_t;

  localparam sbm_pins_t PINS_IDLE = '{default: '1};
endpackage

// >>> rtl/sbm_chip.sv
// One 32-bit wide memory of the module, byte-lane organised
`timescale 1ns/100ps
module sbm_chip (
  input wire logic clock,
  input wire logic rst,
  input wire logic access,
  input wire logic [sbm_pkg::ADDR_W-1:0] addr,
  input wire logic [sbm_pkg::CHIP_LANES-1:0] lane_we,
  input wire logic [sbm_pkg::CHIP_W-1:0] wdata,
  output logic [sbm_pkg::CHIP_W-1:0] rdata
);
  localparam int DEPTH = 1 << sbm_pkg::ADDR_W;
  localparam int LW = sbm_pkg::LANE_W;

  genvar i;
  generate
    for (i = 0; i < sbm_pkg::CHIP_LANES; i++) begin : g_lane
      logic [LW-1:0] mem [DEPTH];

      // Write timing comes from the registered controls alone
      always_ff @(posedge clock) begin
        if (access && lane_we[i]) begin
          mem[addr] <= wdata[i*LW +: LW];
        end
      end

      // A written lane is forwarded so rdata shows it right after the write edge
      always_ff @(posedge clock) begin
        if (rst) begin
          rdata[i*LW +: LW] <= sbm_pkg::LANE_RST;
        end else if (access && lane_we[i]) begin
          rdata[i*LW +: LW] <= wdata[i*LW +: LW];
        end else if (access) begin
          rdata[i*LW +: LW] <= mem[addr];
        end
      end
    end
  endgenerate
endmodule

// >>> rtl/sbm_port.sv
// Pin-side logic of the 32K x 64 synchronous burst memory module
`timescale 1ns/100ps
// What this block does
// - Controller strobe restarts burst at new address
// - Controller strobe, all enables: access per writes
// - Controller strobe, enable inactive: power down
// - Byte writes only while write permit low
// - Global write low writes every byte
// - Order select low: linear burst order
// - Order select high or open: interleaved
// - Open order select reads high via pull-up
// - Data bus is eight ascending byte lanes
// - Presence lines ground third line, size code
// - All synchronous inputs registered on rising edge
// - Three chip enables must all be active
// - Output enable and order select are unclocked
// - Writes complete with self-generated timing
// - Processor strobe with chip enable: restart; read only if all three enables active
// - Advance low steps counter, high holds
// - Each byte enable owns one lane
// - Written data readable on the next cycle
module sbm_port (
  input wire logic clock,
  input wire logic rst,
  input wire sbm_pkg::sbm_pins_t bus_pins,
  input wire logic out_en_n,
  input wire logic burst_order_sel,
  input wire logic burst_order_driven,
  output logic [sbm_pkg::DATA_W-1:0] data_io_bus_out,
  output logic data_io_bus_oe_n,
  output sbm_pkg::sbm_presence_t presence_id_out,
  output sbm_pkg::sbm_presence_t presence_id_oe_n,
  output logic power_down
);
  localparam int AW = sbm_pkg::ADDR_W;
  localparam int BW = sbm_pkg::BURST_W;

  sbm_pkg::sbm_pins_t pins_q;
  sbm_pkg::sbm_state_t state_reg;
  sbm_pkg::sbm_state_t state_next;
  logic [AW-1:0] base_reg;
  logic [AW-1:0] base_next;
  logic [BW-1:0] count_reg;
  logic [BW-1:0] count_next;
  logic [BW-1:0] low_bits;
  logic [AW-1:0] acc_addr;
  logic oe_meta_reg;
  logic oe_sync_reg;
  logic mode_meta_reg;
  logic mode_sync_reg;
  logic pin_sync_reg;
  logic drv_meta_reg;
  logic drv_sync_reg;
  logic mode_pin;
  logic ce_ok;
  logic all_en;
  logic proc_start;
  logic ctrl_start;
  logic load;
  logic sel_next;
  logic wr_req;
  logic acc_rd;
  logic acc_wr;
  logic [sbm_pkg::LANES-1:0] lane_we_c;
  logic [sbm_pkg::LANES-1:0] lane_we_m;

  // Bus pins share the module clock, so one register stage suffices
  always_ff @(posedge clock) begin
    if (rst) begin
      pins_q <= sbm_pkg::PINS_IDLE;
    end else begin
      pins_q <= bus_pins;
    end
  end

  // A floating order select reads as the pulled-up level
  assign mode_pin = drv_sync_reg ? pin_sync_reg
                                 : sbm_pkg::MODE_PULLUP;

  // Unclocked pins cross into the clock domain through two stages
  always_ff @(posedge clock) begin
    if (rst) begin
      oe_meta_reg <= sbm_pkg::SYNC_RST;
      oe_sync_reg <= sbm_pkg::SYNC_RST;
    end else begin
      oe_meta_reg <= out_en_n;
      oe_sync_reg <= oe_meta_reg;
    end
  end

  // Pin and float flag are synced apart before the pull-up choice, so
  // the mux never sees a metastable level; costs one more edge of lag
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_meta_reg <= sbm_pkg::MODE_PULLUP;
      pin_sync_reg <= sbm_pkg::MODE_PULLUP;
      drv_meta_reg <= sbm_pkg::SYNC_RST;
      drv_sync_reg <= sbm_pkg::SYNC_RST;
      mode_sync_reg <= sbm_pkg::MODE_PULLUP;
    end else begin
      mode_meta_reg <= burst_order_sel;
      pin_sync_reg <= mode_meta_reg;
      drv_meta_reg <= burst_order_driven;
      drv_sync_reg <= drv_meta_reg;
      mode_sync_reg <= mode_pin;
    end
  end

  // Enable decode; the processor strobe is ignored without chip enable
  always_comb begin
    ce_ok = !pins_q.chip_en_n;
    all_en = ce_ok && pins_q.depth_sel_hi
             && !pins_q.depth_sel_lo_n;
    proc_start = !pins_q.proc_addr_strobe_n && ce_ok;
    ctrl_start = !proc_start && !pins_q.ctrl_addr_strobe_n;
    load = proc_start || ctrl_start;
  end

  // Per-lane write decode; global write overrides permit and lanes
  genvar i;
  generate
    for (i = 0; i < sbm_pkg::LANES; i++) begin : g_we
      assign lane_we_c[i] = !pins_q.all_bytes_write_n
        || (!pins_q.byte_write_permit_n
            && !pins_q.byte_lane_we_n[i]);
    end
  endgenerate

  assign wr_req = |lane_we_c;

  // Burst address: a strobe reloads the base, advance steps the count
  always_comb begin
    base_next = base_reg;
    count_next = count_reg;
    sel_next = (state_reg != sbm_pkg::SBM_IDLE);
    if (load) begin
      base_next = pins_q.addr;
      count_next = sbm_pkg::BURST_RST;
      sel_next = all_en;
    end else if (sel_next && !pins_q.burst_advance_n) begin
      count_next = count_reg + sbm_pkg::BURST_STEP;
    end
  end

  // Only the two low word bits move; the order is read once synced.
  // Mode is not latched per burst since it may not change in use.
  always_comb begin
    if (mode_sync_reg == sbm_pkg::MODE_LINEAR) begin
      low_bits = base_next[BW-1:0] + count_next;
    end else begin
      low_bits = base_next[BW-1:0] ^ count_next;
    end
    acc_addr = {base_next[AW-1:BW], low_bits};
  end

  // A processor start reads when all three enables are active; other selected cycles follow writes
  always_comb begin
    acc_rd = sel_next && (proc_start || !wr_req);
    acc_wr = sel_next && !proc_start && wr_req;
    lane_we_m = acc_wr ? lane_we_c : '0;
    case (1'b1)
      !sel_next: state_next = sbm_pkg::SBM_IDLE;
      acc_wr: state_next = sbm_pkg::SBM_WRITE;
      default: state_next = sbm_pkg::SBM_READ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_reg <= sbm_pkg::BASE_RST;
      count_reg <= sbm_pkg::BURST_RST;
    end else begin
      base_reg <= base_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= sbm_pkg::SBM_IDLE;
    end else begin
      case (state_next)
        sbm_pkg::SBM_IDLE: state_reg <= sbm_pkg::SBM_IDLE;
        sbm_pkg::SBM_READ: state_reg <= sbm_pkg::SBM_READ;
        sbm_pkg::SBM_WRITE: state_reg <= sbm_pkg::SBM_WRITE;
        default: state_reg <= sbm_pkg::SBM_IDLE;
      endcase
    end
  end

  // Deselect status lets the system time its retention entry
  always_ff @(posedge clock) begin
    if (rst) begin
      power_down <= !sbm_pkg::SEL_RST;
    end else begin
      power_down <= !sel_next;
    end
  end

  // Drivers follow the synced enable; any lane write turns them off
  always_ff @(posedge clock) begin
    if (rst) begin
      data_io_bus_oe_n <= 1'b1;
    end else begin
      data_io_bus_oe_n <= oe_sync_reg || wr_req
                          || (state_next != sbm_pkg::SBM_READ);
    end
  end

  // Grounded lines are driven low, open lines released
  always_ff @(posedge clock) begin
    presence_id_out <= sbm_pkg::PRES_LEVEL;
    presence_id_oe_n <= ~sbm_pkg::PRES_GND;
  end

  // Two 32-bit memories side by side form the eight lanes
  genvar c;
  generate
    for (c = 0; c < sbm_pkg::CHIPS; c++) begin : g_chip
      sbm_chip u_chip (
        .clock(clock),
        .rst(rst),
        .access(acc_rd || acc_wr),
        .addr(acc_addr),
        .lane_we(lane_we_m[c*sbm_pkg::CHIP_LANES +: sbm_pkg::CHIP_LANES]),
        .wdata(pins_q.data_io_bus[c*sbm_pkg::CHIP_W +: sbm_pkg::CHIP_W]),
        .rdata(data_io_bus_out[c*sbm_pkg::CHIP_W +: sbm_pkg::CHIP_W])
      );
    end
  endgenerate

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_ctrl_load;
    ctrl_start && all_en;
  endsequence

  sequence s_full_write;
    acc_wr && (lane_we_c == 8'hff);
  endsequence

  sequence s_load_lin;
    load && all_en && (mode_sync_reg == 1'b0);
  endsequence

  sequence s_load_int;
    load && all_en && (mode_sync_reg == 1'b1);
  endsequence

  AST_CTRL_LOAD: assert property (
    s_ctrl_load |=> base_reg == $past(pins_q.addr) && count_reg == 2'h0)
    else $error("Controller strobe did not load the address");

  AST_DESELECT: assert property (
    (ctrl_start && !all_en) |=> power_down && data_io_bus_oe_n)
    else $error("Deselect cycle did not power down");

  AST_PERMIT_HIGH: assert property (
    (pins_q.byte_write_permit_n && pins_q.all_bytes_write_n)
      |-> !acc_wr ##1 state_reg != sbm_pkg::SBM_WRITE)
    else $error("Write taken while byte write permit high");

  AST_GLOBAL_ALL: assert property (
    (acc_wr && !pins_q.all_bytes_write_n) |-> lane_we_m == 8'hff)
    else $error("Global write missed a byte");

  AST_LINEAR_STEP: assert property (
    s_load_lin ##1 (!load && !pins_q.burst_advance_n && !mode_sync_reg)
      |-> acc_addr[1:0] == $past(pins_q.addr[1:0]) + 2'h1)
    else $error("Linear burst stepped wrongly");

  AST_INTERLEAVE_STEP: assert property (
    s_load_int ##1 (!load && !pins_q.burst_advance_n && mode_sync_reg)
      ##1 (!load && !pins_q.burst_advance_n && mode_sync_reg)
      |-> acc_addr[1:0] == ($past(pins_q.addr[1:0], 2) ^ 2'h2))
    else $error("Interleaved burst stepped wrongly");

  AST_ADV_HOLD: assert property (
    (!load && sel_next && pins_q.burst_advance_n)
      |-> acc_addr == $past(acc_addr))
    else $error("Burst address moved without advance");

  AST_PROC_READ: assert property (
    proc_start |-> (!acc_wr && (acc_rd == all_en))
      ##1 ((state_reg == sbm_pkg::SBM_READ) == $past(all_en)))
    else $error("Processor strobe did not read");

  AST_PASS_THROUGH: assert property (
    s_full_write ##1 (acc_rd && acc_addr == $past(acc_addr))
      |=> data_io_bus_out == $past(pins_q.data_io_bus, 2))
    else $error("Read after write missed written data");

  AST_DRIVE_GATE: assert property (
    !data_io_bus_oe_n
      |-> $past(!oe_sync_reg) && state_reg == sbm_pkg::SBM_READ)
    else $error("Drivers on without output enable");

  AST_PRESENCE: assert property (
    ##1 presence_id_oe_n == 4'hb && presence_id_out == 4'h0)
    else $error("Presence code wrong");
endmodule

// >>> testbench/sbm_ctrl_model.sv
// Controller model that drives the module's synchronous pins
`timescale 1ns/100ps
module sbm_ctrl_model (
  input wire logic clock,
  input wire sbm_pkg::sbm_pins_t cmd,
  input wire logic [63:0] dev_data,
  input wire logic dev_oe_n,
  output sbm_pkg::sbm_pins_t bus_pins
);
  logic [63:0] last_reg;
  logic proc_reg;
  logic wr;
  assign wr = !cmd.all_bytes_write_n || !cmd.byte_write_permit_n;
  always_ff @(posedge clock) begin
    proc_reg <= !cmd.proc_addr_strobe_n;
    if (wr) begin
      last_reg <= cmd.data_io_bus;
    end
  end
  // No pull-up on data: a released bus shows the inverse, not a held value
  always_comb begin
    bus_pins = cmd;
    if (!wr) begin
      bus_pins.data_io_bus = !dev_oe_n ? dev_data : ~last_reg;
    end
    if (proc_reg && wr) begin
      bus_pins.burst_advance_n = 1'b1;
    end
  end
endmodule

// >>> testbench/test_sbm_port.sv
// Self-checking bench of the burst memory module port
`timescale 1ns/100ps
module test_sbm_port;
  logic clock = 0;
  logic rst = 1;
  logic out_en_n = 0;
  logic burst_order_sel = 1;
  logic burst_order_driven = 1;
  sbm_pkg::sbm_pins_t cmd = sbm_pkg::PINS_IDLE;
  sbm_pkg::sbm_pins_t bus_pins, p;
  sbm_pkg::sbm_presence_t pres, pres_oe_n;
  logic [63:0] dout;
  logic dout_oe_n, power_down, pdm = 1;
  logic [14:0] a;
  logic [63:0] mem [int];
  logic [63:0] qv [$];
  int qk [$];
  logic qp [$];
  int error_cnt = 0, checks_done = 0, base = 0, cnt = 0, sel = 0;

  sbm_ctrl_model sbm_ctrl_model_i (.clock(clock), .cmd(cmd),
    .dev_data(dout), .dev_oe_n(dout_oe_n), .bus_pins(bus_pins));
  sbm_port sbm_port_i (.clock(clock), .rst(rst), .bus_pins(bus_pins),
    .out_en_n(out_en_n), .burst_order_sel(burst_order_sel),
    .burst_order_driven(burst_order_driven), .data_io_bus_out(dout),
    .data_io_bus_oe_n(dout_oe_n), .presence_id_out(pres),
    .presence_id_oe_n(pres_oe_n), .power_down(power_down));

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  function automatic sbm_pkg::sbm_pins_t mk(input logic [14:0] ad,
      input logic [63:0] d);
    mk = sbm_pkg::PINS_IDLE;
    mk.addr = ad;
    mk.data_io_bus = d;
    mk.chip_en_n = 0;
    mk.depth_sel_lo_n = 0;
    mk.ctrl_addr_strobe_n = 0;
  endfunction

  // Reference model of one bus cycle; results are due two edges later
  task automatic cyc(input sbm_pkg::sbm_pins_t c);
    int k;
    logic ps;
    logic wq;
    logic [14:0] ad;
    k = 0;
    ps = !c.proc_addr_strobe_n && !c.chip_en_n;
    wq = !c.all_bytes_write_n
      || (!c.byte_write_permit_n && c.byte_lane_we_n != 8'hff);
    if (!c.ctrl_addr_strobe_n || ps) begin
      base = c.addr;
      cnt = 0;
      sel = !c.chip_en_n && c.depth_sel_hi && !c.depth_sel_lo_n;
      pdm = !sel;
    end else if (sel && !c.burst_advance_n) begin
      cnt++;
    end
    ad = 15'(base);
    ad[1:0] = (burst_order_driven && !burst_order_sel) ?
      ad[1:0] + cnt[1:0] : ad[1:0] ^ cnt[1:0];
    if (sel) begin
      // A processor start reads, but write pins keep the drivers off
      k = wq ? 3 : 1;
      if (wq && !ps) begin
        k = 2;
        for (int i = 0; i < 8; i++) begin
          if (!c.all_bytes_write_n || !c.byte_lane_we_n[i]) begin
            mem[ad][8*i+:8] = c.data_io_bus[8*i+:8];
          end
        end
      end
    end
    @(posedge clock);
    cmd <= c;
    qk.push_back(k);
    qv.push_back(mem.exists(ad) ? mem[ad] : 'x);
    qp.push_back(pdm);
  endtask

  task automatic quiet(input int n);
    sbm_pkg::sbm_pins_t q;
    q = mk(a, 0);
    q.depth_sel_hi = 0;
    repeat (n) cyc(q);
  endtask

  always @(posedge clock) begin
    #1;
    if (qk.size() == 3) begin
      chk(power_down, qp[0]);
      if (qk[0] != 0) chk(dout, qv[0]);
      if (qk[0] == 1) chk(dout_oe_n, out_en_n);
      if (qk[0] > 1) chk(dout_oe_n, 1'b1);
      void'(qk.pop_front());
      void'(qv.pop_front());
      void'(qp.pop_front());
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(18146));
    a = 15'($urandom()) & 15'h7ffc;
    repeat (20) cyc(sbm_pkg::PINS_IDLE);
    rst <= 0;
    quiet(2);
    chk(pres_oe_n, 4'hb);
    chk(pres_oe_n | pres, 4'hb);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      p = mk(a + 15'(i), {$urandom(), $urandom()});
      p.all_bytes_write_n = 0;
      cyc(p);
    end
    for (int i = 0; i < 6; i++) begin
      p = mk(a + 15'(i % 4), {$urandom(), $urandom()});
      p.byte_write_permit_n = i[0];
      p.byte_lane_we_n = 8'($urandom()) & 8'h7f;
      cyc(p);
      cyc(mk(a + 15'(i % 4), 0));
    end
    $display("write test done");
    // Order pin moves only while deselected, then settles past the sync
    for (int m = 0; m < 3; m++) begin
      quiet(2);
      burst_order_sel <= m[0];
      burst_order_driven <= m < 2;
      quiet(4);
      cyc(mk(a + 15'(1 + m), 0));
      p = sbm_pkg::PINS_IDLE;
      for (int j = 0; j < 4; j++) begin
        p.burst_advance_n = j == 3;
        cyc(p);
      end
    end
    $display("burst test done");
    quiet(1);
    p = sbm_pkg::PINS_IDLE;
    p.proc_addr_strobe_n = 0;
    cyc(p);
    p = mk(a + 15'h1, {$urandom(), $urandom()});
    p.ctrl_addr_strobe_n = 1;
    p.proc_addr_strobe_n = 0;
    p.all_bytes_write_n = 0;
    cyc(p);
    p.proc_addr_strobe_n = 1;
    cyc(p);
    cyc(mk(a + 15'h1, 0));
    for (int e = 0; e < 3; e++) begin
      p = mk(a, {$urandom(), $urandom()});
      p.all_bytes_write_n = 0;
      p.chip_en_n = e == 0;
      p.depth_sel_hi = e != 1;
      p.depth_sel_lo_n = e == 2;
      cyc(p);
      cyc(mk(a, 0));
    end
    $display("strobe test done");
    quiet(3);
    out_en_n <= 1;
    quiet(4);
    cyc(mk(a, 0));
    quiet(3);
    out_en_n <= 0;
    quiet(4);
    cyc(mk(a, 0));
    quiet(3);
    $display("output enable test done");
    test_done();
  end
endmodule
